// File: design/sfr_consts.vh
// constants for the serial flash status and configuration register block
// Function
// RULE_01: in four-line mode, quad identity read shifts id out on falling edges, msb first
// RULE_02: identity bytes go maker, type, density, repeating until chip select rises
// RULE_03: host frames quad identity read with chip select low, reads bytes, raises it
// RULE_04: status read answers at any time, even while busy
// RULE_05: configuration read answers at any time, even while busy
// RULE_06: reads accepted as 8-clock single-line or 2-clock four-line commands
// RULE_07: host should poll busy flag clear before issuing new commands
// RULE_08: status bit 0 is busy flag, high during program, erase or register write
// RULE_09: status bit 1 write-enable latch gates program, erase and register write
// RULE_10: program or erase targeting a protected area is ignored
// RULE_11: host confirms busy clear first, then write-enable latch clear
// RULE_12: status bits 5..2 protect level, default zero, changed only by register write
// RULE_13: chip erase runs only when all protect level bits are zero
// RULE_14: status bit 6 quad enable selects four-line io, disables pin protection
// RULE_15: bit 7 with protect pin low blocks register writes, bits 7,5..2 read only
// RULE_16: config bits 2..0 volatile driver strength, default 30 ohm code
// RULE_17: config bit 3 one-time top/bottom select, default top
// RULE_18: config bit 5 address width, set by enter, cleared by exit command
// RULE_19: config bits 7..6 volatile dummy-cycle select, bit 4 reserved
// RULE_20: dummy field default 00 selects clocks per read type, 11 gives ten; the code gives a fixed 8 for 00
// RULE_21: after register write framing, busy for write time, then busy and latch clear
// RULE_22: write enable command sets latch, write disable clears it
// RULE_23: reset returns volatile bits to their defaults
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define SFR_CMD_QUAD_ID     8'haf
`define SFR_CMD_STATUS_RD   8'h05
`define SFR_CMD_CONFIG_RD   8'h15
`define SFR_CMD_REG_WR      8'h01
`define SFR_CMD_WRITE_ENABLE_CMD        8'h06
`define SFR_CMD_WRDIS       8'h04
`define SFR_CMD_WIDE_EN     8'hb7
`define SFR_CMD_WIDE_EX     8'he9
`define SFR_CMD_PAGE_PROG   8'h02
`define SFR_CMD_SECT_ERASE  8'h20
`define SFR_CMD_HALF_ERASE  8'h52
`define SFR_CMD_BLK_ERASE   8'hd8
`define SFR_CMD_CHIP_ERASE  8'h60

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define SFR_ST_BUSY   0
`define SFR_ST_WEL    1
`define SFR_ST_BP_LO  2
`define SFR_ST_BP_HI  5
`define SFR_ST_QE     6
`define SFR_ST_WDIS   7

// ----------------------------------------------------------------
// configuration field positions and reset values
// ----------------------------------------------------------------
`define SFR_CF_DRV_HI  2
`define SFR_CF_TB      3
`define SFR_CF_WIDE    5
`define SFR_CF_DC_LO   6
`define SFR_CF_DC_HI   7
`define SFR_DRV_RST    3'h7
`define SFR_DC_RST     2'h0
`define SFR_BP_RST     4'h0

// ----------------------------------------------------------------
// timing: self-timed write periods in microseconds
// ----------------------------------------------------------------
`define SFR_CLK_MHZ     100
`define SFR_TW_US       40
`define SFR_TPROG_US    10
`define SFR_CYC(us)     ((us) * `SFR_CLK_MHZ)

`endif

// File: design/sfr_regs.v
// serial flash status/configuration registers with the serial command front end
`timescale 1ns/100ps
`include "sfr_consts.vh"

module sfr_regs #(
    parameter WRITE_CYCLES = `SFR_CYC(`SFR_TW_US),
    parameter PROG_CYCLES = `SFR_CYC(`SFR_TPROG_US),
    parameter [7:0] ID_MAKER = 8'h5a,   // arbitrary value
    parameter [7:0] ID_TYPE = 8'h3c,    // arbitrary value
    parameter [7:0] ID_DENSITY = 8'h1e, // arbitrary value
    parameter [31:0] HALF_SIZE = 32'h0100_0000
) (
    // clock and reset
    input wire clk_i,
    input wire rstn_i,
    // serial bus from the host
    input wire cs_n_i,
    input wire sclk_i,
    input wire [3:0] sio_i,
    output reg [3:0] sio_o,
    output reg [3:0] sio_oe_o,
    // write-protect pin level
    input wire wp_n_i,
    // array engine side
    output wire quad_enable_o,
    output wire [2:0] driver_strength_o,
    output wire [1:0] dummy_cycle_o,
    output wire [3:0] dummy_clocks_o,
    output wire address_width_o,
    output wire hw_protect_o,
    output reg array_op_start_o,
    output reg [7:0] array_op_cmd_o,
    output reg [31:0] array_op_addr_o
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [6:0] sync1_r;
reg [6:0] sync2_r;
reg sclk_d_r;
always @(posedge clk_i) begin
    if (!rstn_i) begin
        // sclk bit resets low to match its idle level: no false edge
        sync1_r <= 7'h5f;
        sync2_r <= 7'h5f;
        sclk_d_r <= 1'b0;
    end else begin
        sync1_r <= {cs_n_i, sclk_i, wp_n_i, sio_i};
        sync2_r <= sync1_r;
        sclk_d_r <= sync2_r[5];
    end
end
wire cs_n_s = sync2_r[6];
wire sclk_s = sync2_r[5];
wire wp_n_s = sync2_r[4];
wire [3:0] sio_s = sync2_r[3:0];
wire sclk_rise = sclk_s & ~sclk_d_r;
wire sclk_fall = ~sclk_s & sclk_d_r;
reg cs_d_r;
always @(posedge clk_i) begin
    if (!rstn_i)
        cs_d_r <= 1'b1;
    else
        cs_d_r <= cs_n_s;
end
wire cs_rise = cs_n_s & ~cs_d_r;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg busy_r;
reg wel_r;
reg [3:0] bp_r;
reg qe_r;
reg wdis_r;
reg [2:0] drv_r;
reg tb_r;
reg wide_r;
reg [1:0] dc_r;
wire [7:0] status_w = {wdis_r, qe_r, bp_r, wel_r, busy_r};
wire [7:0] config_w = {dc_r, wide_r, 1'b0, tb_r, drv_r}; // [RULE_19]
wire quad_mode = qe_r;
// quad enable takes over the protect pin, so hardware protection lapses
wire hardware_protect_state = wdis_r & ~wp_n_s & ~qe_r; // [RULE_14] [RULE_15]

assign quad_enable_o = qe_r;
assign driver_strength_o = drv_r;
assign dummy_cycle_o = dc_r;
assign address_width_o = wide_r;
assign hw_protect_o = hardware_protect_state;
// fast-read dummy count; 11 selects ten for every variant
assign dummy_clocks_o = (dc_r == 2'h3) ? 4'ha : // [RULE_20]
                        (dc_r == 2'h1) ? 4'h6 : 4'h8;

// ----------------------------------------------------------------
// frame shifter
// ----------------------------------------------------------------
localparam ST_CMD = 2'h0;
localparam ST_ADDR = 2'h1;
localparam ST_DATA = 2'h2;
localparam ST_OUT = 2'h3;
reg [1:0] st_r;
reg [7:0] cmd_r;
reg [7:0] sh_r;
reg [5:0] bits_r;
reg [31:0] addr_r;
reg [4:0] dbits_r;
reg [15:0] wdata_r;
reg [7:0] obyte_r;
reg [1:0] oidx_r;
reg [2:0] obit_r;
reg out_en_r;

// single-line mode reads only the data-in line
wire [7:0] sh_in = quad_mode ? {sh_r[3:0], sio_s} :
                               {sh_r[6:0], sio_s[0]}; // [RULE_06]
wire [5:0] step = quad_mode ? 6'h4 : 6'h1;
wire cmd_done = (bits_r + step) == 6'h8;
wire [5:0] abits = wide_r ? 6'h20 : 6'h18; // [RULE_18]
wire is_prog_erase = (cmd_r == `SFR_CMD_PAGE_PROG) |
                     (cmd_r == `SFR_CMD_SECT_ERASE) |
                     (cmd_r == `SFR_CMD_HALF_ERASE) |
                     (cmd_r == `SFR_CMD_BLK_ERASE);

// byte chosen for the next output load
function [7:0] out_byte;
    input [7:0] c;
    input [1:0] idx;
    begin
        if (c == `SFR_CMD_STATUS_RD)
            out_byte = status_w; // [RULE_04]
        else if (c == `SFR_CMD_CONFIG_RD)
            out_byte = config_w; // [RULE_05]
        else if (idx == 2'h0)
            out_byte = ID_MAKER; // [RULE_02]
        else if (idx == 2'h1)
            out_byte = ID_TYPE;
        else
            out_byte = ID_DENSITY;
    end
endfunction
wire [1:0] next_idx = (oidx_r == 2'h2) ? 2'h0 : oidx_r + 2'h1;

// protected range per level; top or bottom counted from half size
wire [31:0] prot_len = (bp_r == 4'h0) ? 32'h0 :
                       (bp_r >= 4'h9) ? 32'hffff_ffff :
                       (HALF_SIZE >> (4'h8 - bp_r));
wire addr_prot = (bp_r != 4'h0) &&
                 (tb_r ? (addr_r < prot_len) : // [RULE_17]
                  (addr_r >= (32'hffff_ffff - prot_len)));

// ----------------------------------------------------------------
// self-timed write timer
// ----------------------------------------------------------------
reg [31:0] tmr_r;
reg pend_reg_r;
reg [15:0] pend_data_r;
reg [4:0] pend_len_r;

always @(posedge clk_i) begin
    if (!rstn_i) begin
        st_r <= ST_CMD;
        cmd_r <= 8'h00;
        sh_r <= 8'h00;
        bits_r <= 6'h0;
        addr_r <= 32'h0;
        dbits_r <= 5'h0;
        wdata_r <= 16'h0;
        obyte_r <= 8'h00;
        oidx_r <= 2'h0;
        obit_r <= 3'h0;
        out_en_r <= 1'b0;
        sio_o <= 4'h0;
        sio_oe_o <= 4'h0;
        busy_r <= 1'b0; // [RULE_23]
        wel_r <= 1'b0;
        wide_r <= 1'b0;
        drv_r <= `SFR_DRV_RST;
        dc_r <= `SFR_DC_RST;
        bp_r <= `SFR_BP_RST;
        qe_r <= 1'b0;
        wdis_r <= 1'b0;
        tb_r <= 1'b0;
        tmr_r <= 32'h0;
        pend_reg_r <= 1'b0;
        pend_data_r <= 16'h0;
        pend_len_r <= 5'h0;
        array_op_start_o <= 1'b0;
        array_op_cmd_o <= 8'h00;
        array_op_addr_o <= 32'h0;
    end else begin
        array_op_start_o <= 1'b0;
        // busy countdown; on expiry apply the held write
        if (busy_r) begin
            if (tmr_r <= 32'h1) begin
                busy_r <= 1'b0; // [RULE_08] [RULE_21]
                wel_r <= 1'b0;
                if (pend_reg_r) begin
                    pend_reg_r <= 1'b0;
                    if (!hardware_protect_state) begin
                        bp_r <= pend_data_r[8 + `SFR_ST_BP_HI -: 4]; // [RULE_12]
                        wdis_r <= pend_data_r[8 + `SFR_ST_WDIS];
                    end
                    qe_r <= pend_data_r[8 + `SFR_ST_QE];
                    if (pend_len_r == 5'h10) begin
                        drv_r <= pend_data_r[2:0]; // [RULE_16]
                        dc_r <= pend_data_r[7:6];
                        tb_r <= tb_r | pend_data_r[3]; // [RULE_17]
                    end
                end
            end else begin
                tmr_r <= tmr_r - 32'h1;
            end
        end
        if (cs_n_s) begin
            st_r <= ST_CMD;
            bits_r <= 6'h0;
            dbits_r <= 5'h0;
            out_en_r <= 1'b0;
            sio_oe_o <= 4'h0;
            oidx_r <= 2'h0;
        end else if (sclk_rise) begin
            case (st_r)
            ST_CMD: begin
                sh_r <= sh_in;
                bits_r <= bits_r + step;
                if (cmd_done) begin
                    cmd_r <= sh_in;
                    bits_r <= 6'h0;
                    addr_r <= 32'h0;
                    if ((sh_in == `SFR_CMD_STATUS_RD) ||
                        (sh_in == `SFR_CMD_CONFIG_RD) ||
                        ((sh_in == `SFR_CMD_QUAD_ID) && quad_mode)) begin
                        st_r <= ST_OUT; // [RULE_01]
                        obyte_r <= out_byte(sh_in, 2'h0);
                        oidx_r <= 2'h0;
                        obit_r <= 3'h0;
                    end else if (sh_in == `SFR_CMD_REG_WR)
                        st_r <= ST_DATA;
                    else if ((sh_in == `SFR_CMD_PAGE_PROG) ||
                             (sh_in == `SFR_CMD_SECT_ERASE) ||
                             (sh_in == `SFR_CMD_HALF_ERASE) ||
                             (sh_in == `SFR_CMD_BLK_ERASE))
                        st_r <= ST_ADDR;
                    else
                        st_r <= ST_DATA;
                end
            end
            ST_ADDR: begin
                if (bits_r < abits) begin
                    addr_r <= quad_mode ? {addr_r[27:0], sio_s} :
                                          {addr_r[30:0], sio_s[0]};
                    bits_r <= bits_r + step;
                end
            end
            ST_DATA: begin
                if (dbits_r < 5'h10) begin
                    wdata_r <= quad_mode ? {wdata_r[11:0], sio_s} :
                                           {wdata_r[14:0], sio_s[0]};
                    dbits_r <= dbits_r + step[4:0];
                end
            end
            ST_OUT: begin
            end
            default: st_r <= ST_CMD;
            endcase
        end else if (sclk_fall && (st_r == ST_OUT)) begin
            // first falling edge after command starts the output
            out_en_r <= 1'b1;
            sio_oe_o <= quad_mode ? 4'hf : 4'h2;
            if (quad_mode) begin
                sio_o <= (obit_r[2] == 1'b0) ? obyte_r[7:4] : obyte_r[3:0];
                obit_r <= obit_r + 3'h4;
                if (obit_r[2]) begin
                    obyte_r <= out_byte(cmd_r, next_idx);
                    oidx_r <= next_idx;
                    obit_r <= 3'h0;
                end else begin
                    obit_r <= 3'h4;
                end
            end else begin
                sio_o <= {2'b00, obyte_r[3'h7 - obit_r], 1'b0};
                obit_r <= obit_r + 3'h1;
                if (obit_r == 3'h7) begin
                    obyte_r <= out_byte(cmd_r, next_idx);
                    oidx_r <= next_idx;
                end
            end
        end
        // end of frame: commit non-read commands
        // a frame cut inside its command byte must not replay the last one
        if (cs_rise && (st_r != ST_OUT) && (st_r != ST_CMD) && !busy_r) begin
            if (cmd_r == `SFR_CMD_WRITE_ENABLE_CMD && bits_r == 6'h0)
                wel_r <= 1'b1; // [RULE_22]
            else if (cmd_r == `SFR_CMD_WRDIS)
                wel_r <= 1'b0; // [RULE_22]
            else if (cmd_r == `SFR_CMD_WIDE_EN)
                wide_r <= 1'b1; // [RULE_18]
            else if (cmd_r == `SFR_CMD_WIDE_EX)
                wide_r <= 1'b0; // [RULE_18]
            else if (cmd_r == `SFR_CMD_REG_WR && wel_r && !hardware_protect_state && // [RULE_09] [RULE_15]
                     (dbits_r == 5'h8 || dbits_r == 5'h10)) begin
                busy_r <= 1'b1; // [RULE_21]
                tmr_r <= WRITE_CYCLES;
                pend_reg_r <= 1'b1;
                pend_len_r <= dbits_r;
                pend_data_r <= (dbits_r == 5'h8) ? {wdata_r[7:0], 8'h00}
                                                 : wdata_r;
            end else if (cmd_r == `SFR_CMD_CHIP_ERASE && wel_r &&
                         bp_r == 4'h0) begin // [RULE_13]
                busy_r <= 1'b1;
                tmr_r <= PROG_CYCLES;
                array_op_start_o <= 1'b1;
                array_op_cmd_o <= cmd_r;
                array_op_addr_o <= 32'h0;
            end else if (is_prog_erase && wel_r && bits_r >= abits &&
                         !addr_prot) begin // [RULE_09] [RULE_10]
                busy_r <= 1'b1;
                tmr_r <= PROG_CYCLES;
                array_op_start_o <= 1'b1;
                array_op_cmd_o <= cmd_r;
                array_op_addr_o <= addr_r;
            end
        end
    end
end

endmodule // sfr_regs

// File: tb/sfr_regs_sva.sv
// port assertions for the status/configuration register block
`timescale 1ns/100ps
`include "sfr_consts.vh"
module sfr_regs_sva (
    // clock and reset
    input wire clk_i,
    input wire rstn_i,
    // serial bus and pin
    input wire cs_n_i,
    input wire sclk_i,
    input wire [3:0] sio_o,
    input wire [3:0] sio_oe_o,
    input wire wp_n_i,
    // array engine side
    input wire quad_enable_o,
    input wire [2:0] driver_strength_o,
    input wire [1:0] dummy_cycle_o,
    input wire [3:0] dummy_clocks_o,
    input wire address_width_o,
    input wire hw_protect_o,
    input wire array_op_start_o,
    input wire [7:0] array_op_cmd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    oe_idle_a:
    assert property (cs_n_i [*8] |-> sio_oe_o == 4'h0)
        else $error("output enable held after deselect");
    oe_mode_a:
    assert property (sio_oe_o != 4'h0 |->
        sio_oe_o == (quad_enable_o ? 4'hf : 4'h2))
        else $error("output lanes do not match io mode");
    dummy_map_a:
    assert property (dummy_clocks_o == (dummy_cycle_o == 2'h1 ? 4'h6 :
        dummy_cycle_o == 2'h3 ? 4'ha : 4'h8))
        else $error("dummy clock count wrong");
    reset_val_a:
    assert property ($rose(rstn_i) |-> driver_strength_o == 3'h7 &&
        dummy_cycle_o == 2'h0 && !address_width_o && sio_oe_o == 4'h0)
        else $error("volatile fields not at defaults after reset");
    hpm_quad_a:
    assert property (quad_enable_o |-> !hw_protect_o)
        else $error("hardware protection active in quad mode");
    wp_high_a:
    assert property (wp_n_i [*5] |-> !hw_protect_o)
        else $error("hardware protection with pin high");
    data_hold_a:
    assert property (sclk_i [*6] |-> $stable(sio_o))
        else $error("output data moved while serial clock high");
    wide_frame_a:
    assert property ($changed(address_width_o) |-> cs_n_i)
        else $error("address width changed inside a frame");
    start_cmd_a:
    assert property (array_op_start_o |-> cs_n_i && array_op_cmd_o inside
        {`SFR_CMD_PAGE_PROG, `SFR_CMD_SECT_ERASE, `SFR_CMD_HALF_ERASE,
        `SFR_CMD_BLK_ERASE, `SFR_CMD_CHIP_ERASE} ##1 !array_op_start_o)
        else $error("bad array start");
endmodule // sfr_regs_sva

// File: tb/sfr_host.sv
// host controller model driving the serial command bus
`timescale 1ns/100ps
module sfr_host (
    // serial bus toward the device
    output logic cs_n_o = 1'b1,
    output logic sclk_o = 1'b0,
    output logic [3:0] dout_o = 4'h0,
    input wire [3:0] din_i,
    // captured read word, toggle marks a new one
    output logic [31:0] rd_o = 32'h0,
    output logic rd_t_o = 1'b0
);
    localparam realtime H = 62.5;
    // sclk idles low; offset keeps host edges away from clk edges
    task automatic xfer(input bit q, input logic [7:0] c, input int nw,
        input logic [15:0] wd, input int nr, input bit p,
        output logic [31:0] rd);
        logic [23:0] sh;
        int w;
        w = q ? 4 : 1;
        sh = {c, wd};
        rd = 32'h0;
        #1.3 cs_n_o <= 1'b0;
        for (int n = 0; n < 8 + 8 * nw; n += w) begin
            // unused lanes toggle so a stale level cannot pass
            dout_o <= q ? sh[23:20] : {~dout_o[3:1], sh[23]};
            sh = sh << w;
            #H sclk_o <= 1'b1;
            #H sclk_o <= 1'b0;
        end
        for (int n = 0; n < 8 * nr; n += w) begin
            dout_o <= ~dout_o;
            #H sclk_o <= 1'b1;
            rd = q ? {rd[27:0], din_i} : {rd[30:0], din_i[1]};
            #H sclk_o <= 1'b0;
        end
        #H cs_n_o <= 1'b1;
        dout_o <= ~dout_o;
        #(8 * H);
        if (p) begin
            rd_o = rd;
            rd_t_o = ~rd_t_o;
        end
    endtask
endmodule // sfr_host

// File: tb/sfr_regs_test.sv
// self-checking bench for the status/configuration register block
`timescale 1ns/100ps
`include "sfr_consts.vh"
module sfr_regs_test;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wp_n_i = 1'b1;
    logic cs_n, sclk, rd_t, st, qe, aw;
    logic [3:0] hd, sio_out, oe, dclk;
    logic [7:0] acmd, last_cmd;
    logic [31:0] rd_w;
    logic [63:0] exp_q[$];
    int error_cnt = 0;
    int n_compared = 0;
    int n_start = 0;
    wire [3:0] bus = (oe & sio_out) | (~oe & hd);

    always #5 clk_i = ~clk_i;

    // id values are arbitrary
    sfr_regs #(.WRITE_CYCLES(400), .PROG_CYCLES(400), .ID_MAKER(8'ha5),
        .ID_TYPE(8'h96), .ID_DENSITY(8'h4b)) i_sfr_regs (
        .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .sio_i(bus), .sio_o(sio_out), .sio_oe_o(oe), .wp_n_i(wp_n_i),
        .quad_enable_o(qe), .driver_strength_o(), .dummy_cycle_o(),
        .dummy_clocks_o(dclk), .address_width_o(aw), .hw_protect_o(),
        .array_op_start_o(st), .array_op_cmd_o(acmd),
        .array_op_addr_o());
    sfr_host i_sfr_host (.cs_n_o(cs_n), .sclk_o(sclk), .dout_o(hd),
        .din_i(bus), .rd_o(rd_w), .rd_t_o(rd_t));

    task automatic chk(input logic [31:0] g, e, input string s);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic take();
        logic [63:0] e;
        e = exp_q.pop_front();
        chk(rd_w & e[63:32], e[31:0], "read data");
    endtask
    always @(rd_t) take();
    always @(posedge clk_i) if (st === 1'b1) begin
        n_start++;
        last_cmd = acmd;
    end

    task automatic rd(input bit q, input logic [7:0] c, input int n,
        input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        logic [31:0] d;
        exp_q.push_back({m, e});
        @(posedge clk_i);
        i_sfr_host.xfer(q, c, 0, 16'h0, n, 1'b1, d);
    endtask
    task automatic cmd(input bit q, input logic [7:0] c, input int nw,
        input logic [15:0] wd);
        logic [31:0] d;
        @(posedge clk_i);
        i_sfr_host.xfer(q, c, nw, wd, 0, 1'b0, d);
    endtask
    task automatic wr(input bit q, input int nw, input logic [15:0] wd);
        cmd(q, `SFR_CMD_WRITE_ENABLE_CMD, 0, 16'h0);
        cmd(q, `SFR_CMD_REG_WR, nw, wd);
    endtask
    task automatic poll(input bit q);
        logic [31:0] d;
        d = 32'h1;
        for (int i = 0; i < 20 && d[0] !== 1'b0; i++) begin
            @(posedge clk_i);
            i_sfr_host.xfer(q, `SFR_CMD_STATUS_RD, 0, 16'h0, 1, 1'b0, d);
        end
        chk(d[0], 1'b0, "busy clear");
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #800000;
        error_cnt++;
        conclude();
    end

    initial begin
        logic [7:0] cf;
        logic tbx;
        void'($urandom(32'he1d6));
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h00);
        rd(0, `SFR_CMD_CONFIG_RD, 1, 32'h07);
        chk(dclk, 4'h8, "default dummy");
        cmd(0, `SFR_CMD_WRITE_ENABLE_CMD, 0, 16'h0);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h02);
        cmd(0, `SFR_CMD_WRDIS, 0, 16'h0);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h00);
        cmd(0, `SFR_CMD_REG_WR, 1, 16'h3c00);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h00);
        $display("test latch done");
        // every dummy code; top/bottom set once, later clear must not stick
        tbx = 1'b0;
        for (int dc = 0; dc < 4; dc++) begin
            cf = {dc[1:0], 2'h0, dc == 2, 3'($urandom_range(5, 7))};
            tbx = tbx | cf[3];
            wr(0, 2, {8'h14, cf});
            rd(0, `SFR_CMD_STATUS_RD, 1, 32'h03, 32'h03);
            poll(0);
            rd(0, `SFR_CMD_STATUS_RD, 1, 32'h14);
            rd(0, `SFR_CMD_CONFIG_RD, 1, {cf[7:4], tbx, cf[2:0]});
            chk(dclk, dc == 1 ? 6 : dc == 3 ? 10 : 8, "dummy");
        end
        $display("test config done");
        wr(0, 0, 16'h0);
        cmd(0, `SFR_CMD_CHIP_ERASE, 0, 16'h0);
        chk(n_start, 0, "erase refused");
        wr(0, 1, 16'h0000);
        poll(0);
        wr(0, 0, 16'h0);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h02);
        cmd(0, `SFR_CMD_WRITE_ENABLE_CMD, 0, 16'h0);
        cmd(0, `SFR_CMD_CHIP_ERASE, 0, 16'h0);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h01, 32'h01);
        poll(0);
        chk({n_start, last_cmd}, {32'd1, 8'h60}, "erase ran");
        $display("test erase done");
        cmd(0, `SFR_CMD_WIDE_EN, 0, 16'h0);
        rd(0, `SFR_CMD_CONFIG_RD, 1, 32'h20, 32'h20);
        chk(aw, 1'b1, "wide address");
        cmd(0, `SFR_CMD_WIDE_EX, 0, 16'h0);
        rd(0, `SFR_CMD_CONFIG_RD, 1, 32'h00, 32'h20);
        $display("test width done");
        wr(0, 1, 16'h8000);
        poll(0);
        @(posedge clk_i) wp_n_i <= 1'b0;
        wr(0, 1, 16'h0000);
        cmd(0, `SFR_CMD_WRDIS, 0, 16'h0);
        rd(0, `SFR_CMD_STATUS_RD, 1, 32'h80);
        @(posedge clk_i) wp_n_i <= 1'b1;
        wr(0, 1, 16'h4000);
        poll(0);
        chk(qe, 1'b1, "quad enable");
        rd(1, `SFR_CMD_STATUS_RD, 1, 32'h40);
        rd(1, `SFR_CMD_CONFIG_RD, 1, {cf[7:4], tbx, cf[2:0]});
        rd(1, `SFR_CMD_QUAD_ID, 4, 32'ha5964ba5);
        $display("test quad done");
        @(posedge clk_i) rstn_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(0, `SFR_CMD_CONFIG_RD, 1, 32'h07);
        $display("test reset done");
        conclude();
    end
endmodule // sfr_regs_test

bind sfr_regs sfr_regs_sva i_sfr_regs_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .sio_o(sio_o), .sio_oe_o(sio_oe_o),
    .wp_n_i(wp_n_i), .quad_enable_o(quad_enable_o),
    .driver_strength_o(driver_strength_o), .dummy_cycle_o(dummy_cycle_o),
    .dummy_clocks_o(dummy_clocks_o), .address_width_o(address_width_o),
    .hw_protect_o(hw_protect_o), .array_op_start_o(array_op_start_o),
    .array_op_cmd_o(array_op_cmd_o));
